// *** test/srd_node_model.sv ***
/*
  Far serial node: sends one message to the port, then asks the port to
  reply and counts the cycles in which the port holds transmission back.
  Assumes send is a one-cycle pulse in the pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module srd_node_model (
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Bench control
  input  wire logic   send,
  output logic [15:0] low_cnt,
  // Port side
  input  wire logic   tx_start_ok,
  output logic        rx_msg_done,
  output logic        tx_start_req
);
  // Message pulse, reply request and blocked cycle count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_msg_done  <= 1'b0;
      tx_start_req <= 1'b0;
      low_cnt      <= 16'h0000;
    end else begin
      rx_msg_done <= send;
      low_cnt     <= send ? 16'h0000 : low_cnt + 16'(!tx_start_ok);
      if (send) begin
        tx_start_req <= 1'b1;
      end else if (tx_start_ok) begin
        tx_start_req <= 1'b0;
      end
    end
  end
endmodule : srd_node_model
`default_nettype wire

// *** test/srd_reply_delay_bench.sv ***
/*
  Self-checking bench of the reply delay block: APB master tasks, a far
  node model and random delay settings with corner values.
  Assumes the millisecond tick is shortened to a few clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module srd_reply_delay_bench;
  import srd_pkg::*;
  localparam int unsigned TK = 4;
  logic        pclk, presetn, psel, penable, pwrite, send, err;
  logic        pready, pslverr, rx_msg_done, tx_start_req, tx_start_ok, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] low_cnt, d;
  int          fails, checked;

  // Clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  srd_reply_delay #(.TICKS(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_msg_done(rx_msg_done), .tx_start_req(tx_start_req), .tx_start_ok(tx_start_ok), .irq(irq));

  srd_node_model node (.pclk(pclk), .presetn(presetn), .send(send), .low_cnt(low_cnt),
    .tx_start_ok(tx_start_ok), .rx_msg_done(rx_msg_done), .tx_start_req(tx_start_req));

  // Random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Blocked cycles: the receive cycle plus the full wait
  function automatic logic [15:0] exp_low(input logic [15:0] n);
    return 16'(n * TK + 1);
  endfunction : exp_low

  task automatic conclude();
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer, then two idle cycles
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
    if (n >= 50) begin
      fails++;
      conclude();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rdchk

  task automatic exec(input logic [15:0] v);
    wr(DELAY_OFS, {16'h0000, v});
    wr(CTRL_OFS, 32'h1);
  endtask : exec

  task automatic fire();
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
  endtask : fire

  // Wait for the node's reply to go out, then compare the hold-off
  task automatic reply_chk(input logic [15:0] n);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (tx_start_req !== 1'b0 && k < 2000);
    if (k >= 2000) begin
      fails++;
      conclude();
    end
    chk("blocked cycles", {16'h0000, exp_low(n)}, {16'h0000, low_cnt});
  endtask : reply_chk

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    send    = 1'b0;
    fails   = 0;
    checked = 0;
    seed    = 32'h63B8;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("delay rst", DELAY_OFS, 32'h0, 32'hFFFFFFFF);
    rdchk("applied rst", APPLIED_OFS, 32'h0, 32'hFFFFFFFF);
    rdchk("status rst", STATUS_OFS, 32'h0, 32'h3);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    wr(IRQ_MASK_OFS, 32'h1);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
      exec(d);
      rdchk("status done", STATUS_OFS, 32'h1, 32'h3);
      rdchk("applied", APPLIED_OFS, {16'h0000, d}, 32'hFFFFFFFF);
      wr(DELAY_OFS, {16'h0000, ~d});
      wr(CTRL_OFS, 32'h1);
      rdchk("applied held", APPLIED_OFS, {16'h0000, d}, 32'hFFFFFFFF);
      chk("irq set", 32'h1, {31'h0, irq});
      rdchk("irq stat done", IRQ_STAT_OFS, 32'h1, 32'h1);
      chk("irq clear", 32'h0, {31'h0, irq});
      wr(CTRL_OFS, 32'h0);
      rdchk("status clear", STATUS_OFS, 32'h0, 32'h3);
      d = 16'(seed[17:16]);
      exec(d);
      wr(CTRL_OFS, 32'h0);
      fire();
      reply_chk(d);
    end
    // Apply refused while a wait runs, then a new wait once that one has ended
    exec(16'h0003);
    wr(CTRL_OFS, 32'h0);
    fire();
    wr(CTRL_OFS, 32'h1);
    rdchk("status error", STATUS_OFS, 32'h6, 32'hF);
    rdchk("error code", ERRCODE_OFS, {16'h0000, ERR_BUSY}, 32'hFFFFFFFF);
    rdchk("applied kept", APPLIED_OFS, 32'h3, 32'hFFFFFFFF);
    fire();
    reply_chk(16'h0003);
    rdchk("irq stat wait", IRQ_STAT_OFS, 32'h6, 32'h6);
    wr(CTRL_OFS, 32'h0);
    rdchk("status err clear", STATUS_OFS, 32'h8, 32'hF);
    rdchk("error code clear", ERRCODE_OFS, 32'h0, 32'hFFFFFFFF);
    wr(IRQ_MASK_OFS, 32'h0);
    exec(16'h0001);
    chk("irq masked", 32'h0, {31'h0, irq});
    conclude();
  end
endmodule : srd_reply_delay_bench
`default_nettype wire

// *** verilog/srd_ms_timer.sv ***
/*
  Millisecond turnaround timer: a divider makes a one-cycle tick every
  TICK_CYCLES clocks, and a down counter counts the loaded milliseconds.
  Assumes start is a one-cycle pulse in the pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module srd_ms_timer
  import srd_pkg::*;
#(
  parameter int unsigned TICKS = TICK_CYCLES,
  parameter int unsigned CNT_W = DELAY_W
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  // Status
  output logic                  busy,
  output logic                  expired
);
  localparam int unsigned DIV_W = (TICKS > 1) ? $clog2(TICKS) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICKS - 1);

  logic [DIV_W-1:0] div_q;
  logic [CNT_W-1:0] cnt_q;
  logic             busy_q;
  logic             exp_q;
  logic             tick;

  assign tick    = busy_q && (div_q == DIV_LAST);
  assign busy    = busy_q;
  assign expired = exp_q;

  // Tick divider, restarted with each wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (start || tick || !busy_q) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // Millisecond down counter; zero load adds no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      exp_q  <= 1'b0;
    end else begin
      exp_q <= 1'b0;
      if (start) begin
        cnt_q  <= load;  // RULE9
        busy_q <= (load != '0);  // RULE9
      end else if (tick) begin
        cnt_q <= cnt_q - CNT_W'(1);
        if (cnt_q == CNT_W'(1)) begin
          busy_q <= 1'b0;
          exp_q  <= 1'b1;
        end
      end
    end
  end

  // No tick on the cycle right after a tick, for TICKS above one
  property p_tick_gap;
    @(posedge pclk) disable iff (!presetn)
    tick && (TICKS > 1) |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick repeated on next cycle"); // RULE9

  // Counter steps down by one on each tick
  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
    tick && !start |=> cnt_q == $past(cnt_q) - CNT_W'(1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step on tick"); // RULE9

endmodule : srd_ms_timer
`default_nettype wire

// *** verilog/srd_pkg.sv ***
/*
  Shared constants and types of the serial reply delay block: register map,
  reset values, error codes and time base.
  Assumes a 50 MHz system clock and a 32-bit APB register bus.
*/
package srd_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned TICK_PERIOD_NS = 1_000_000;  // One millisecond
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Widths
  localparam int unsigned DELAY_W = 16;
  localparam int unsigned ADDR_W  = 8;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] DELAY_OFS     = 8'h04;
  localparam logic [7:0] STATUS_OFS    = 8'h08;
  localparam logic [7:0] ERRCODE_OFS   = 8'h0C;
  localparam logic [7:0] APPLIED_OFS   = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h18;

  // Field positions
  localparam int unsigned CTRL_EXEC_BIT = 0;

  // Reset values
  localparam logic [15:0] DELAY_RST    = 16'h0000;
  localparam logic [2:0]  IRQ_MASK_RST = 3'h0;

  // Error codes (zero means no error)
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_BUSY = 16'h0001;  // Apply refused during a wait

  // Sticky interrupt events
  typedef struct packed {
    logic elapsed;  // Turnaround wait finished
    logic error;    // Operation failed
    logic done;     // Delay applied
  } srd_irq_t;

  // Operation state
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DONE  = 3'b010,
    ST_ERROR = 3'b100
  } srd_op_state_t;

endpackage : srd_pkg

// *** verilog/srd_reply_delay.sv ***
/*
  Serial reply delay controller: an APB-programmed turnaround delay that
  holds back the serial port's next transmission after a received message.
  Assumes the serial port pulses rx_msg_done once per complete received
  message and starts a transmission only while tx_start_ok is high.
*/
// Added by the designer: the APB slave port and the placing of the registers.
//
// Function
// RULE1: An operation starts only on a low-to-high edge of the execute bit.
// RULE2: Delay 0..65535 ms, default zero, captured when execute rises.
// RULE3: Done rises once applied, cleared when execute falls.
// RULE4: Error rises on failure or illegal input, cleared when execute falls.
// RULE5: While error is set, a matching error code is shown.
// RULE6: The delay applies in master and slave roles alike.
// RULE7: As master, the next message waits the full delay after a response.
// RULE8: As slave, the reply waits the full delay after the request.
// RULE9: A millisecond tick counter times the wait; zero adds no wait.
`timescale 1ns/100ps
`default_nettype none
module srd_reply_delay
  import srd_pkg::*;
#(
  parameter int unsigned TICKS = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Serial port
  input  wire logic              rx_msg_done,
  input  wire logic              tx_start_req,
  output logic                   tx_start_ok,
  // Interrupt
  output logic                   irq
);

  logic                 exec_q;
  logic                 exec_prev_q;
  logic [DELAY_W-1:0]   delay_set_q;
  logic [DELAY_W-1:0]   applied_q;
  logic [15:0]          err_code_q;
  srd_op_state_t        op_q;
  srd_irq_t             irq_stat_q;
  srd_irq_t             irq_mask_q;
  srd_irq_t             irq_set;
  logic [31:0]          prdata_q;
  logic                 pslverr_d;
  logic                 wr_en;
  logic                 rd_en;
  logic                 addr_ok;
  logic                 exec_rise;
  logic                 exec_fall;
  logic                 apply_ok;
  logic                 apply_bad;
  logic                 wait_busy;
  logic                 wait_exp;
  logic                 done;
  logic                 error;

  // APB access decode; zero wait states
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = psel && penable && pslverr_d;

  // Mapped offsets
  always_comb begin
    case (paddr)
      CTRL_OFS, DELAY_OFS, STATUS_OFS, ERRCODE_OFS,
      APPLIED_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS: addr_ok = 1'b1;
      default:                                 addr_ok = 1'b0;
    endcase
    pslverr_d = !addr_ok;
  end

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_q      <= 1'b0;
      delay_set_q <= DELAY_RST;  // RULE2
      irq_mask_q  <= IRQ_MASK_RST;
    end else if (wr_en) begin
      case (paddr)
        CTRL_OFS:     exec_q      <= pwdata[CTRL_EXEC_BIT];
        DELAY_OFS:    delay_set_q <= pwdata[DELAY_W-1:0];  // RULE2
        IRQ_MASK_OFS: irq_mask_q  <= pwdata[2:0];
        default:      exec_q      <= exec_q;
      endcase
    end
  end

  // Execute edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_prev_q <= 1'b0;
    end else begin
      exec_prev_q <= exec_q;
    end
  end

  assign exec_rise = exec_q && !exec_prev_q;  // RULE1
  assign exec_fall = !exec_q && exec_prev_q;

  // Applying while a turnaround wait runs is refused
  assign apply_ok  = exec_rise && !wait_busy;
  assign apply_bad = exec_rise && wait_busy;

  // Capture of the delay value at the execute edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_q <= DELAY_RST;
    end else if (apply_ok) begin
      applied_q <= delay_set_q;  // RULE2
    end
  end

  // Operation state: done or error until execute falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= ST_IDLE;
    end else begin
      case (op_q)
        ST_IDLE: begin
          if (apply_ok) begin
            op_q <= ST_DONE;  // RULE3
          end else if (apply_bad) begin
            op_q <= ST_ERROR;  // RULE4
          end
        end
        ST_DONE: begin
          if (exec_fall) begin
            op_q <= ST_IDLE;  // RULE3
          end
        end
        ST_ERROR: begin
          if (exec_fall) begin
            op_q <= ST_IDLE;  // RULE4
          end
        end
        default: op_q <= ST_IDLE;
      endcase
    end
  end

  assign done  = (op_q == ST_DONE);
  assign error = (op_q == ST_ERROR);

  // Error code follows the error flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_code_q <= ERR_NONE;
    end else if (apply_bad && op_q == ST_IDLE) begin
      err_code_q <= ERR_BUSY;  // RULE5
    end else if (exec_fall) begin
      err_code_q <= ERR_NONE;
    end
  end

  // Turnaround timer, restarted by each received message in either role
  srd_ms_timer #(
    .TICKS (TICKS),
    .CNT_W (DELAY_W)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (rx_msg_done),  // RULE6
    .load    (applied_q),
    .busy    (wait_busy),
    .expired (wait_exp)
  );

  // Transmit gate: no new message or reply while waiting
  assign tx_start_ok = !wait_busy && !rx_msg_done;  // RULE7 RULE8

  // Sticky interrupt status; set wins over clear-on-read
  always_comb begin
    irq_set         = '0;
    irq_set.done    = apply_ok;
    irq_set.error   = apply_bad && op_q == ST_IDLE;
    irq_set.elapsed = wait_exp;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (rd_en && paddr == IRQ_STAT_OFS) begin
      // Clears only reported bits; an event at the setup edge survives
      irq_stat_q <= (irq_stat_q & ~prdata_q[2:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        CTRL_OFS:     prdata_q <= {31'h0000_0000, exec_q};
        DELAY_OFS:    prdata_q <= {16'h0000, delay_set_q};
        STATUS_OFS:   prdata_q <= {28'h000_0000, tx_start_ok, wait_busy, error, done};
        ERRCODE_OFS:  prdata_q <= {16'h0000, err_code_q};
        APPLIED_OFS:  prdata_q <= {16'h0000, applied_q};
        IRQ_STAT_OFS: prdata_q <= {29'h0000_0000, irq_stat_q};
        IRQ_MASK_OFS: prdata_q <= {29'h0000_0000, irq_mask_q};
        default:      prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Done only after a rising execute edge
  property p_done_cause;
    @(posedge pclk) disable iff (!presetn)
    $rose(done) |-> $past(exec_rise) && !$past(wait_busy);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done rose without execute edge"); // RULE1

  // Captured delay equals the setting at the edge
  property p_capture;
    @(posedge pclk) disable iff (!presetn)
    apply_ok |=> applied_q == $past(delay_set_q);
  endproperty
  a_capture: assert property (p_capture) else $error("delay not captured at execute edge"); // RULE2

  // Done and error drop one cycle after execute falls
  property p_flags_clear;
    @(posedge pclk) disable iff (!presetn)
    exec_fall |=> !done && !error;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared by execute fall"); // RULE3

  // Refused apply raises error on the next cycle
  property p_error_set;
    @(posedge pclk) disable iff (!presetn)
    apply_bad && op_q == ST_IDLE |=> error;
  endproperty
  a_error_set: assert property (p_error_set) else $error("refused apply did not raise error"); // RULE4

  // Error code is ERR_BUSY whenever error is set
  property p_code_match;
    @(posedge pclk) disable iff (!presetn)
    error |-> err_code_q == ERR_BUSY;
  endproperty
  a_code_match: assert property (p_code_match) else $error("error code missing while error set"); // RULE5

  // A received message with nonzero delay blocks transmit in its own cycle and the next two
  property p_hold_after_rx;
    @(posedge pclk) disable iff (!presetn)
    rx_msg_done && applied_q != 16'h0000 |-> !tx_start_ok ##1 !tx_start_ok [*2];
  endproperty
  a_hold_after_rx: assert property (p_hold_after_rx) else $error("transmit allowed during wait"); // RULE7

  // Zero delay releases transmit one cycle after the received message
  property p_zero_delay;
    @(posedge pclk) disable iff (!presetn)
    rx_msg_done && applied_q == 16'h0000 |=> tx_start_ok || rx_msg_done;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay still held transmit"); // RULE9

  // A wait not cut by a new message ends only at expiry
  property p_no_early_release;
    @(posedge pclk) disable iff (!presetn)
    $fell(wait_busy) && !$past(rx_msg_done) |-> wait_exp ##0 $past(wait_busy, 2);
  endproperty
  a_no_early_release: assert property (p_no_early_release) else $error("wait ended without expiry"); // RULE8

  // A new event is latched even during a status read
  property p_irq_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (|irq_set) |=> (irq_stat_q & $past(irq_set)) == $past(irq_set);
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("interrupt event lost");

  // Status bits drop only through a status read
  property p_irq_keep;
    @(posedge pclk) disable iff (!presetn)
    !(rd_en && paddr == IRQ_STAT_OFS) |=> (irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q);
  endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("status bit dropped without read");

  // A status read clears only the bits it reported
  property p_read_clear;
    @(posedge pclk) disable iff (!presetn)
    rd_en && paddr == IRQ_STAT_OFS |=> ($past(irq_stat_q) & ~irq_stat_q & ~prdata_q[2:0]) == 3'h0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("unreported status bit cleared");

  // Error code returns to none when execute falls
  property p_code_clear;
    @(posedge pclk) disable iff (!presetn)
    exec_fall |=> err_code_q == ERR_NONE;
  endproperty
  a_code_clear: assert property (p_code_clear) else $error("error code kept after execute fall"); // RULE5

  // A refused apply leaves the delay in use untouched
  property p_refuse_keeps;
    @(posedge pclk) disable iff (!presetn)
    apply_bad |=> applied_q == $past(applied_q);
  endproperty
  a_refuse_keeps: assert property (p_refuse_keeps) else $error("refused apply changed delay"); // RULE4

  // A received message with nonzero delay arms the wait
  property p_rx_arms;
    @(posedge pclk) disable iff (!presetn)
    rx_msg_done && applied_q != 16'h0000 |=> wait_busy;
  endproperty
  a_rx_arms: assert property (p_rx_arms) else $error("received message did not arm wait"); // RULE8

  // A wait only starts from a received message with nonzero delay
  property p_busy_cause;
    @(posedge pclk) disable iff (!presetn)
    $rose(wait_busy) |-> $past(rx_msg_done) && $past(applied_q) != 16'h0000;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("wait started without cause"); // RULE9

  // A held execute bit starts no new operation
  property p_no_retrigger;
    @(posedge pclk) disable iff (!presetn)
    exec_q && exec_prev_q |=> op_q == $past(op_q);
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) else $error("operation changed without edge"); // RULE1

  // Expiry frees the transmitter at once
  property p_expire_frees;
    @(posedge pclk) disable iff (!presetn)
    wait_exp |-> tx_start_ok || rx_msg_done;
  endproperty
  a_expire_frees: assert property (p_expire_frees) else $error("transmit held after expiry"); // RULE7

  // Main scenarios
  c_apply: cover property (@(posedge pclk) disable iff (!presetn) apply_ok ##1 done);
  c_refuse: cover property (@(posedge pclk) disable iff (!presetn) apply_bad ##1 error);
  c_wait_held: cover property (@(posedge pclk) disable iff (!presetn)
    wait_busy && tx_start_req ##1 wait_exp);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_zero_wait: cover property (@(posedge pclk) disable iff (!presetn) rx_msg_done && applied_q == 16'h0000);

endmodule : srd_reply_delay
`default_nettype wire
